// ### design/gpg_cfg.svh
// Purpose: Offsets, masks and reset values of the port group.
// Assumes: Included by every design file that decodes registers.
// Notes: Offsets are byte addresses on the register bus.
`ifndef GPG_CFG_SVH
`define GPG_CFG_SVH
`define GPG_OFF_P0_DATA 8'h00
`define GPG_OFF_P0_DIR 8'h04
`define GPG_OFF_P0_PU 8'h08
`define GPG_OFF_P1_DATA 8'h0C
`define GPG_OFF_P1_DIR 8'h10
`define GPG_OFF_P1_PU 8'h14
`define GPG_OFF_P3_DATA 8'h18
`define GPG_OFF_P3_DIR 8'h1C
`define GPG_OFF_P3_PU 8'h20
`define GPG_OFF_STATUS 8'h24
`define GPG_P0_MASK 8'h63
`define GPG_P1_MASK 8'hFF
`define GPG_P3_MASK 8'h0F
`define GPG_DBG_MASK 8'h06
`define GPG_DIR_RST 8'hFF
`define GPG_LATCH_RST 8'h00
`define GPG_PU_RST 8'h00
`define GPG_RESP_OKAY 2'h0
`define GPG_RESP_SLVERR 2'h2
`endif

// ### design/gpg_pkg.sv
// Purpose: Types shared by the port group modules.
// Assumes: Eight-bit lanes per port; narrow ports use a mask.
// Notes: None.
package gpg_pkg;
  typedef logic [7:0] gpg_addr_t;
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pu;
    logic [7:0] sampled;
    logic [7:0] drv_o;
    logic [7:0] drv_oe;
    logic [7:0] pull;
  } gpg_bank_state_t;
  typedef struct packed {
    logic we_data;
    logic we_dir;
    logic we_pu;
    logic [7:0] wdata;
  } gpg_bank_wr_t;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] pu;
  } gpg_bank_rd_t;
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pull;
  } gpg_pin_drive_t;
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] o;
  } gpg_alt_t;
  typedef struct packed {
    logic aw_full;
    gpg_addr_t awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpg_axi_state_t;
endpackage

// ### design/gpg_port_bank.sv
// Purpose: One port: output latch, direction, pull-up and pin drive.
// Assumes: Pin levels are synchronous to clk_in.
// Notes: Bits outside IMPL_MASK never drive and read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "gpg_cfg.svh"
module gpg_port_bank import gpg_pkg::*; #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire gpg_bank_wr_t wr_in,
  input wire gpg_alt_t alt_in,
  input wire logic [7:0] force_in_in,
  input wire logic [7:0] pin_in,
  output gpg_bank_rd_t rd_out,
  output gpg_pin_drive_t drive_out,
  output logic [7:0] level_out
);
  gpg_bank_state_t s;
  gpg_bank_state_t next_s;
  logic [7:0] is_in;
  logic [7:0] rd_in_mode;

  always_comb begin
    next_s = s;
    next_s.sampled = pin_in & IMPL_MASK;
    if (wr_in.we_data) begin
      next_s.latch = wr_in.wdata & IMPL_MASK;
    end
    if (wr_in.we_dir) begin
      next_s.dir = wr_in.wdata | ~IMPL_MASK;
    end
    if (wr_in.we_pu) begin
      next_s.pu = wr_in.wdata & IMPL_MASK;
    end
    is_in = next_s.dir | force_in_in;
    next_s.drv_oe = ~is_in & IMPL_MASK;
    next_s.drv_o = ((alt_in.oe & alt_in.o) |
                    (~alt_in.oe & next_s.latch)) & next_s.drv_oe;
    // Pull-ups act only on pins that are inputs.
    next_s.pull = next_s.pu & is_in & IMPL_MASK;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.dir <= `GPG_DIR_RST;
      s.latch <= `GPG_LATCH_RST;
      s.pu <= `GPG_PU_RST;
    end else begin
      s <= next_s;
    end
  end

  // Output pins read back the latch, input pins the sampled level.
  // A pin forced to input by debug use reads back as an input too.
  assign rd_in_mode = s.dir | force_in_in;
  assign rd_out.data = ((rd_in_mode & s.sampled) |
                        (~rd_in_mode & s.latch)) & IMPL_MASK;
  assign rd_out.dir = s.dir & IMPL_MASK;
  assign rd_out.pu = s.pu & IMPL_MASK;
  assign drive_out.o = s.drv_o;
  assign drive_out.oe = s.drv_oe;
  assign drive_out.pull = s.pull;
  assign level_out = s.sampled;
endmodule
`default_nettype wire

// ### design/gpg_port_top.sv
// Purpose: Ports 0, 1 and 3 with their registers on AXI4-Lite.
// Assumes: Pin inputs are synchronous; one clock, async reset.
// Notes: Alternate functions drive through the alt inputs.
// Operation
// - Port 0 four pins with output latch
// - Port 0 direction set per bit
// - Port 0 pull-up per input bit
// - Reset makes port 0 all inputs
// - Port 0 shares timer and select pins
// - Port 1 eight pins, per-bit direction
// - Port 1 pull-up per input bit
// - Reset makes port 1 all inputs
// - Port 1 shares interrupt, serial, timer pins
// - Port 3 four pins, per-bit direction
// - Port 3 pull-up per input bit
// - Reset inputs; port 3 shares interrupts, timers
// - Port 3 bits 1, 2 select debug mode
`timescale 1ns/1ps
`default_nettype none
`include "gpg_cfg.svh"
module gpg_port_top import gpg_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire gpg_addr_t s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire gpg_addr_t s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [7:0] p0_pin_in,
  output logic [7:0] p0_pin_out,
  output logic [7:0] p0_pin_oe_out,
  output logic [7:0] p0_pullup_out,
  input wire gpg_alt_t p0_alt_in,
  output logic [7:0] p0_level_out,
  input wire logic [7:0] p1_pin_in,
  output logic [7:0] p1_pin_out,
  output logic [7:0] p1_pin_oe_out,
  output logic [7:0] p1_pullup_out,
  input wire gpg_alt_t p1_alt_in,
  output logic [7:0] p1_level_out,
  input wire logic [7:0] p3_pin_in,
  output logic [7:0] p3_pin_out,
  output logic [7:0] p3_pin_oe_out,
  output logic [7:0] p3_pullup_out,
  input wire gpg_alt_t p3_alt_in,
  output logic [7:0] p3_level_out,
  input wire logic dbg_enable_in,
  output logic [1:0] dbg_mode_sel_out
);
  gpg_axi_state_t s;
  gpg_axi_state_t next_s;
  gpg_bank_wr_t wr0;
  gpg_bank_wr_t wr1;
  gpg_bank_wr_t wr3;
  gpg_bank_rd_t rd0;
  gpg_bank_rd_t rd1;
  gpg_bank_rd_t rd3;
  gpg_pin_drive_t drv0;
  gpg_pin_drive_t drv1;
  gpg_pin_drive_t drv3;
  logic [7:0] lvl0;
  logic [7:0] lvl1;
  logic [7:0] lvl3;
  logic [7:0] dbg_force;
  logic commit;
  logic wr_lane;
  logic wr_hit;
  logic ar_take;
  logic [31:0] rd_word;
  logic rd_hit;

  // A write completes once address and data are both held and no response is pending.
  assign commit = s.aw_full && s.w_full && !s.bvalid;
  assign wr_lane = s.wstrb[0];
  assign ar_take = s_axi_arvalid_in && !s.rvalid;

  // Debug mode takes port 3 bits 1 and 2 as inputs.
  assign dbg_force = dbg_enable_in ? `GPG_DBG_MASK : 8'h00;

  always_comb begin
    wr0 = '0;
    wr1 = '0;
    wr3 = '0;
    wr0.wdata = s.wdata[7:0];
    wr1.wdata = s.wdata[7:0];
    wr3.wdata = s.wdata[7:0];
    wr_hit = 1'b1;
    case (s.awaddr)
      `GPG_OFF_P0_DATA: begin
        wr0.we_data = commit && wr_lane;
      end
      `GPG_OFF_P0_DIR: begin
        wr0.we_dir = commit && wr_lane;
      end
      `GPG_OFF_P0_PU: begin
        wr0.we_pu = commit && wr_lane;
      end
      `GPG_OFF_P1_DATA: begin
        wr1.we_data = commit && wr_lane;
      end
      `GPG_OFF_P1_DIR: begin
        wr1.we_dir = commit && wr_lane;
      end
      `GPG_OFF_P1_PU: begin
        wr1.we_pu = commit && wr_lane;
      end
      `GPG_OFF_P3_DATA: begin
        wr3.we_data = commit && wr_lane;
      end
      `GPG_OFF_P3_DIR: begin
        wr3.we_dir = commit && wr_lane;
      end
      `GPG_OFF_P3_PU: begin
        wr3.we_pu = commit && wr_lane;
      end
      `GPG_OFF_STATUS: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr_in)
      `GPG_OFF_P0_DATA: begin
        rd_word[7:0] = rd0.data;
      end
      `GPG_OFF_P0_DIR: begin
        rd_word[7:0] = rd0.dir;
      end
      `GPG_OFF_P0_PU: begin
        rd_word[7:0] = rd0.pu;
      end
      `GPG_OFF_P1_DATA: begin
        rd_word[7:0] = rd1.data;
      end
      `GPG_OFF_P1_DIR: begin
        rd_word[7:0] = rd1.dir;
      end
      `GPG_OFF_P1_PU: begin
        rd_word[7:0] = rd1.pu;
      end
      `GPG_OFF_P3_DATA: begin
        rd_word[7:0] = rd3.data;
      end
      `GPG_OFF_P3_DIR: begin
        rd_word[7:0] = rd3.dir;
      end
      `GPG_OFF_P3_PU: begin
        rd_word[7:0] = rd3.pu;
      end
      `GPG_OFF_STATUS: begin
        rd_word[2:0] = {lvl3[2:1], dbg_enable_in};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_s = s;
    if (s_axi_awvalid_in && !s.aw_full) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !s.w_full) begin
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_wdata_in;
      next_s.wstrb = s_axi_wstrb_in;
    end
    if (s.bvalid && s_axi_bready_in) begin
      next_s.bvalid = 1'b0;
    end
    if (commit) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_hit ? `GPG_RESP_OKAY : `GPG_RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready_in) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = rd_hit ? `GPG_RESP_OKAY : `GPG_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready_out = !s.aw_full;
  assign s_axi_wready_out = !s.w_full;
  assign s_axi_bvalid_out = s.bvalid;
  assign s_axi_bresp_out = s.bresp;
  assign s_axi_arready_out = !s.rvalid;
  assign s_axi_rvalid_out = s.rvalid;
  assign s_axi_rdata_out = s.rdata;
  assign s_axi_rresp_out = s.rresp;

  gpg_port_bank #(.IMPL_MASK(`GPG_P0_MASK)) u_port0 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_in(wr0),
    .alt_in(p0_alt_in),
    .force_in_in(8'h00),
    .pin_in(p0_pin_in),
    .rd_out(rd0),
    .drive_out(drv0),
    .level_out(lvl0)
  );

  gpg_port_bank #(.IMPL_MASK(`GPG_P1_MASK)) u_port1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_in(wr1),
    .alt_in(p1_alt_in),
    .force_in_in(8'h00),
    .pin_in(p1_pin_in),
    .rd_out(rd1),
    .drive_out(drv1),
    .level_out(lvl1)
  );

  gpg_port_bank #(.IMPL_MASK(`GPG_P3_MASK)) u_port3 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_in(wr3),
    .alt_in(p3_alt_in),
    .force_in_in(dbg_force),
    .pin_in(p3_pin_in),
    .rd_out(rd3),
    .drive_out(drv3),
    .level_out(lvl3)
  );

  // Sampled levels also feed the peripherals that share the pins.
  assign p0_pin_out = drv0.o;
  assign p0_pin_oe_out = drv0.oe;
  assign p0_pullup_out = drv0.pull;
  assign p0_level_out = lvl0;
  assign p1_pin_out = drv1.o;
  assign p1_pin_oe_out = drv1.oe;
  assign p1_pullup_out = drv1.pull;
  assign p1_level_out = lvl1;
  assign p3_pin_out = drv3.o;
  assign p3_pin_oe_out = drv3.oe;
  assign p3_pullup_out = drv3.pull;
  assign p3_level_out = lvl3;
  assign dbg_mode_sel_out = lvl3[2:1];

  p0_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ((p0_pin_oe_out | p0_pullup_out) & ~`GPG_P0_MASK) == 8'h00)
    else $error("port 0 unimplemented bit active");

  p0_dir_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr0.we_dir |=> p0_pin_oe_out ==
      (~$past(s.wdata[7:0]) & `GPG_P0_MASK))
    else $error("port 0 enable does not follow direction write");

  p0_pull_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr0.we_pu && rd0.dir == `GPG_P0_MASK && !wr0.we_dir
      |=> p0_pullup_out == ($past(s.wdata[7:0]) & `GPG_P0_MASK))
    else $error("port 0 pull-up does not follow write");

  p0_reset_in_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(rst_in) |-> p0_pin_oe_out == 8'h00 ##1
      (!$past(wr0.we_dir) -> p0_pin_oe_out == 8'h00))
    else $error("port 0 not input after reset");

  p1_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr1.we_data && rd1.dir == 8'h00 && !wr1.we_dir &&
      p1_alt_in.oe == 8'h00
      |=> p1_pin_out == $past(s.wdata[7:0]))
    else $error("port 1 pin does not drive latch");

  p1_pull_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (p1_pullup_out & p1_pin_oe_out) == 8'h00)
    else $error("port 1 pull-up on a driven pin");

  p1_reset_in_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(rst_in) |-> p1_pin_oe_out == 8'h00 &&
      rd1.dir == `GPG_DIR_RST)
    else $error("port 1 not input after reset");

  p1_level_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 p1_level_out == $past(p1_pin_in))
    else $error("port 1 level lags pin by more than one cycle");

  p3_dir_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr3.we_dir && !dbg_enable_in |=> p3_pin_oe_out ==
      (~$past(s.wdata[7:0]) & `GPG_P3_MASK))
    else $error("port 3 enable does not follow direction write");

  p3_pull_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    rd3.pu == 8'h00 && !wr3.we_pu |=> p3_pullup_out == 8'h00)
    else $error("port 3 pull-up without enable");

  p3_reset_in_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(rst_in) |-> p3_pin_oe_out == 8'h00)
    else $error("port 3 not input after reset");

  dbg_force_a: assert property (@(posedge clk_in) disable iff (rst_in)
    dbg_enable_in |=> (p3_pin_oe_out & `GPG_DBG_MASK) == 8'h00)
    else $error("debug select pins driven in debug mode");

  read_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ar_take && s_axi_araddr_in == `GPG_OFF_P1_DATA
      |=> s_axi_rvalid_out &&
      s_axi_rdata_out == {24'h000000, $past(rd1.data)})
    else $error("port 1 data read wrong");

  write_resp_a: assert property (@(posedge clk_in) disable iff (rst_in)
    commit |=> s_axi_bvalid_out && !s.aw_full && !s.w_full)
    else $error("write response not raised after commit");
endmodule
`default_nettype wire

// ### sim/gpg_pin_model.sv
// Purpose: Board side of one port: external drivers, pulls, wire level.
// Assumes: The bench releases its drive where the device drives.
// Notes: A pin that nobody drives or pulls toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
module gpg_pin_model #(
  parameter logic [7:0] PD_MASK = 8'h00
) (
  input wire logic clk_in,
  input wire logic [7:0] dev_o_in,
  input wire logic [7:0] dev_oe_in,
  input wire logic [7:0] pull_in,
  input wire logic [7:0] ext_oe_in,
  input wire logic [7:0] ext_o_in,
  output logic [7:0] level_out
);
  logic [7:0] noise = 8'h5A;
  always @(posedge clk_in) begin
    noise <= ~noise;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dev_oe_in[i])
        level_out[i] = dev_o_in[i];
      else if (ext_oe_in[i])
        level_out[i] = ext_o_in[i];
      else if (pull_in[i])
        level_out[i] = 1'b1;
      else if (PD_MASK[i])
        level_out[i] = 1'b0;
      else
        level_out[i] = noise[i];
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the port group over AXI4-Lite.
// Assumes: One pin model per port; index 2 stands for port 3.
// Notes: No serial unit is modelled; port passes drive the alt inputs with random values.
`timescale 1ns/1ps
`default_nettype none
`include "gpg_cfg.svh"
module tb_top;
  import gpg_pkg::*;
  logic clk_in, rst_in, dbg_en;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  gpg_addr_t awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, dbg_sel;
  logic [7:0] pin [3], pin_o [3], oe [3], pu_o [3], lvl [3];
  logic [7:0] ext_oe [3], ext_o [3], sh_lat [3], sh_dir [3], sh_pu [3];
  gpg_alt_t alt [3];
  logic [15:0] seed;
  int error_cnt, comparisons;

  gpg_port_top gpg_port_top_inst (
    .clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready),
    .p0_pin_in(pin[0]), .p0_pin_out(pin_o[0]), .p0_pin_oe_out(oe[0]),
    .p0_pullup_out(pu_o[0]), .p0_alt_in(alt[0]), .p0_level_out(lvl[0]),
    .p1_pin_in(pin[1]), .p1_pin_out(pin_o[1]), .p1_pin_oe_out(oe[1]),
    .p1_pullup_out(pu_o[1]), .p1_alt_in(alt[1]), .p1_level_out(lvl[1]),
    .p3_pin_in(pin[2]), .p3_pin_out(pin_o[2]), .p3_pin_oe_out(oe[2]),
    .p3_pullup_out(pu_o[2]), .p3_alt_in(alt[2]), .p3_level_out(lvl[2]),
    .dbg_enable_in(dbg_en), .dbg_mode_sel_out(dbg_sel));

  for (genvar g = 0; g < 3; g++) begin : pins
    gpg_pin_model #(.PD_MASK(g == 2 ? 8'h02 : 8'h00)) pm (
      .clk_in(clk_in), .dev_o_in(pin_o[g]), .dev_oe_in(oe[g]),
      .pull_in(pu_o[g]), .ext_oe_in(ext_oe[g]), .ext_o_in(ext_o[g]),
      .level_out(pin[g]));
  end

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], ^(seed & 16'hB400)};
    return seed[7:0];
  endfunction

  function automatic logic [7:0] msk(input int p);
    return p == 0 ? `GPG_P0_MASK : (p == 1 ? `GPG_P1_MASK : `GPG_P3_MASK);
  endfunction

  function automatic gpg_addr_t ba(input int p);
    return gpg_addr_t'(p) * 8'h0C;
  endfunction

  // Debug use turns port 3 bits 1 and 2 into inputs.
  function automatic logic [7:0] eff_in(input int p);
    logic [7:0] dm;
    dm = (p == 2 && dbg_en) ? `GPG_DBG_MASK : 8'h00;
    return (sh_dir[p] | dm) & msk(p);
  endfunction

  function automatic logic [7:0] drv(input int p);
    return (alt[p].oe & alt[p].o) | (~alt[p].oe & sh_lat[p]);
  endfunction

  function automatic logic [7:0] wire_lvl(input int p);
    logic [7:0] ed;
    ed = eff_in(p);
    return (drv(p) & ~ed & msk(p)) | (((ext_o[p] & ~sh_pu[p]) | sh_pu[p]) & ed);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input gpg_addr_t a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic ha, hw, done;
    int n;
    n = 0;
    done = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 50) begin
      @(negedge clk_in);
      ha = awvalid && awready;
      hw = wvalid && wready;
      done = bvalid;
      if (done)
        chk(bresp, er);
      @(posedge clk_in);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
      if (done)
        bready <= 1'b0;
      n++;
    end
    chk(done, 1'b1);
  endtask

  task automatic rd(input gpg_addr_t a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ha, done;
    int n;
    n = 0;
    done = 1'b0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 50) begin
      @(negedge clk_in);
      ha = arvalid && arready;
      done = rvalid;
      if (done) begin
        chk(rdata, ed);
        chk(rresp, er);
      end
      @(posedge clk_in);
      if (ha)
        arvalid <= 1'b0;
      if (done)
        rready <= 1'b0;
      n++;
    end
    chk(done, 1'b1);
  endtask

  task automatic rst_chk();
    for (int p = 0; p < 3; p++) begin
      sh_lat[p] = 8'h00;
      sh_dir[p] = 8'hFF;
      sh_pu[p] = 8'h00;
      chk(oe[p], 8'h00);
      chk(pu_o[p], 8'h00);
      rd(ba(p) + 8'h04, msk(p), `GPG_RESP_OKAY);
      rd(ba(p) + 8'h08, 8'h00, `GPG_RESP_OKAY);
    end
  endtask

  task automatic port_pass(input int p);
    logic [7:0] ed, w;
    sh_lat[p] = rnd();
    sh_dir[p] = rnd();
    sh_pu[p] = rnd();
    wr(ba(p), sh_lat[p], 4'hF, `GPG_RESP_OKAY);
    wr(ba(p) + 8'h04, sh_dir[p], 4'hF, `GPG_RESP_OKAY);
    wr(ba(p) + 8'h08, sh_pu[p], 4'hF, `GPG_RESP_OKAY);
    wr(ba(p) + 8'h04, rnd(), 4'h0, `GPG_RESP_OKAY);
    @(posedge clk_in);
    if (p == 2)
      dbg_en <= rnd() > 8'h7F;
    alt[p] <= {rnd(), rnd()};
    ext_o[p] <= rnd();
    @(posedge clk_in);
    ext_oe[p] <= eff_in(p) & ~sh_pu[p];
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    ed = eff_in(p);
    w = wire_lvl(p);
    chk(oe[p], ~ed & msk(p));
    chk(pin_o[p], drv(p) & ~ed & msk(p));
    chk(pu_o[p], sh_pu[p] & ed);
    chk(lvl[p] & msk(p), w);
    if (p == 2)
      chk(dbg_sel, w[2:1]);
    rd(ba(p), (sh_lat[p] & ~ed & msk(p)) | (w & ed), `GPG_RESP_OKAY);
    rd(ba(p) + 8'h04, sh_dir[p] & msk(p), `GPG_RESP_OKAY);
    rd(ba(p) + 8'h08, sh_pu[p] & msk(p), `GPG_RESP_OKAY);
    if (p == 2)
      rd(`GPG_OFF_STATUS, {29'h0, w[2:1], dbg_en}, `GPG_RESP_OKAY);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    summarize();
  end

  // Alternate outputs stay off at first; no serial unit owns any pin.
  initial begin
    {rst_in, seed, dbg_en} = {1'b1, 16'h0049, 1'b0};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    for (int p = 0; p < 3; p++) begin
      alt[p] = 16'h0000;
      ext_oe[p] = 8'hFF;
      ext_o[p] = 8'h00;
    end
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rst_chk();
    wr(8'h28, 8'hA5, 4'hF, `GPG_RESP_SLVERR);
    rd(8'h28, 32'h0, `GPG_RESP_SLVERR);
    wr(`GPG_OFF_P0_PU, 8'hFF, 4'hF, `GPG_RESP_OKAY);
    @(negedge clk_in);
    chk(pu_o[0], `GPG_P0_MASK);
    wr(`GPG_OFF_P1_DIR, 8'h00, 4'hF, `GPG_RESP_OKAY);
    wr(`GPG_OFF_P1_DATA, 8'hA5, 4'hF, `GPG_RESP_OKAY);
    @(negedge clk_in);
    chk(pin_o[1], 8'hA5);
    rd(`GPG_OFF_P1_DATA, 32'h0000_00A5, `GPG_RESP_OKAY);
    for (int it = 0; it < 30; it++) begin
      for (int p = 0; p < 3; p++) begin
        port_pass(p);
      end
    end
    @(posedge clk_in);
    rst_in <= 1'b1;
    dbg_en <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      ext_oe[p] <= 8'hFF;
      ext_o[p] <= 8'h00;
    end
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    rst_chk();
    summarize();
  end
endmodule
`default_nettype wire
